/* File: hw/cpu_seq_pkg.sv */
// constants, operation codes and register map for the sequencer core
// assumes one 50 MHz clock and an external instruction decoder
package cpu_seq_pkg;

  // ----------------------------------------------------------------
  // program side
  // ----------------------------------------------------------------
  localparam int         PC_W         = 10;
  localparam logic [9:0] PC_RESET     = 10'h000;
  localparam int         ROM_DEPTH    = 512;
  localparam logic [9:0] ROM_LIMIT    = 10'h200;
  localparam logic [9:0] TEST_AREA_LO = 10'h3EA;

  // ----------------------------------------------------------------
  // data memory and pointers
  // ----------------------------------------------------------------
  localparam int         NIB_COUNT     = 32;
  localparam logic [4:0] TABLE_LOW_IDX = 5'h00;
  localparam logic [4:0] TABLE_HI_IDX  = 5'h10;
  localparam logic [4:0] RET_LOW_IDX   = 5'h0F;
  localparam logic [4:0] RET_HI_IDX    = 5'h1F;
  localparam logic [7:0] CREG_RESET    = 8'h03;
  localparam int         CREG_DP_LSB   = 4;
  localparam logic [3:0] ACC_MAX       = 4'hF;
  localparam logic [2:0] COND_TIMER    = 3'h5;
  localparam int         COND_SPECIAL  = 3;

  // ----------------------------------------------------------------
  // register port map
  // ----------------------------------------------------------------
  localparam int          ADDR_W     = 11;
  localparam int          ROM_SEL    = 10;
  localparam logic [10:0] ADDR_NIB_LAST = 11'h01F;
  localparam logic [10:0] ADDR_CREG  = 11'h020;
  localparam logic [10:0] ADDR_FLAGS = 11'h021;
  localparam logic [10:0] ADDR_PC    = 11'h022;
  localparam logic [10:0] ADDR_RET   = 11'h023;
  localparam logic [10:0] ADDR_TABLE = 11'h024;
  localparam logic [10:0] ADDR_ACC   = 11'h025;
  localparam int FLAG_CARRY  = 0;
  localparam int FLAG_STATUS = 1;
  localparam int FLAG_DEPTH  = 2;
  localparam int FLAG_RETOK  = 3;

  typedef enum logic [4:0] {
    OP_NOP, OP_BRANCH, OP_JC, OP_JNC, OP_JF, OP_JNF, OP_CALL, OP_RET,
    OP_AND, OP_XOR, OP_OR, OP_RL, OP_RLZ, OP_INC, OP_STEP,
    OP_TRANSFER, OP_PORT_IN, OP_CHECK, OP_PAUSE
  } op_kind_t;

endpackage

/* File: hw/cpu_sequencer_and_flags.sv */
// sequencer, return store, data nibbles, accumulator and flags
// assumes decoded instructions arrive as one-cycle opValid pulses
//
// Notes on behaviour
// - 10-bit counter holds next address, advances by instruction length.
// - taken jumps load the counter with the operand address.
// - call saves counter plus instruction length then jumps; return restores saved address.
// - reset forces the counter to zero.
// - one-bit depth: up on call, down on return, zero at reset.
// - depth overflow or underflow raises a system reset, counter to zero.
// - nothing but call, return and reset changes the depth bit.
// - 10-bit return store, low byte shared with last data word, kept.
// - reset leaves the return store untouched.
// - data access to the shared word makes the upper two bits unknown.
// - 512 words of 10 bits, addressed by the counter.
// - fetch above implemented memory or in test area returns to zero.
// - 32 nibbles as sixteen bytes; only the first clears at reset.
// - table pointer is control bits 5:4 over the first data byte.
// - 4-bit accumulator, left as is at reset.
// - status set by true check, standby release, or met pause.
// - status cleared by false check or unmet pause with flag set.
// - check code 101 tests timer zero, others test key inputs.
// - check operand bit 3 adds the special inputs to the test.
// - and/xor set carry to accumulator bit 3 and operand bit 3.
// - rotates load carry with the old accumulator bit 3.
// - increment and step set carry when accumulator was 0FH.
// - or, transfer and port input clear carry.
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`default_nettype none

module cpu_sequencer_and_flags
  import cpu_seq_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               opValid,
  input  wire op_kind_t           opKind,
  input  wire logic [9:0]         opOperand,
  input  wire logic [1:0]         opLength,
  input  wire logic [3:0]         keyReturnInputs,
  input  wire logic               specialInputZero,
  input  wire logic               specialIoOne,
  input  wire logic               timerZero,
  input  wire logic               standbyRelease,
  input  wire logic               pauseReleaseMet,
  input  wire logic [3:0]         portInData,
  input  wire logic [ADDR_W-1:0]  regAddr,
  input  wire logic [9:0]         regWrData,
  input  wire logic               regWr,
  input  wire logic               regRd,
  output logic      [9:0]         regRdData,
  output logic      [9:0]         instructionAddressCounter,
  output logic      [9:0]         fetchWord,
  output logic                    fetchFault,
  output logic                    systemResetPulse,
  output logic                    standbyEnter,
  output logic      [9:0]         tablePointer,
  output logic      [3:0]         accumulator,
  output logic                    carryBit,
  output logic                    statusFlag
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [9:0] programMemory [ROM_DEPTH];
  logic [3:0] dataNibble    [NIB_COUNT];
  logic       stackDepthBit;
  logic [1:0] returnHigh;
  logic       returnHighKnown;
  logic [7:0] controlRegZero;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  logic       hang;
  logic       doCall;
  logic       doReturn;
  logic       jumpTaken;
  logic       checkTrue;
  logic       busNib;
  logic       romWrite;
  logic [9:0] nextSeq;
  logic [9:0] returnStore;

  assign fetchFault = instructionAddressCounter >= ROM_LIMIT;
  assign nextSeq    = instructionAddressCounter + {8'h00, opLength};
  assign hang = opValid && !fetchFault &&
                ((opKind == OP_CALL && stackDepthBit) ||
                 (opKind == OP_RET && !stackDepthBit));
  assign doCall   = opValid && !fetchFault && opKind == OP_CALL && !hang;
  assign doReturn = opValid && !fetchFault && opKind == OP_RET && !hang;
  assign systemResetPulse = hang;
  assign returnStore = {returnHigh, dataNibble[RET_HI_IDX],
                        dataNibble[RET_LOW_IDX]};
  assign tablePointer = {controlRegZero[CREG_DP_LSB+1:CREG_DP_LSB],
                         dataNibble[TABLE_HI_IDX],
                         dataNibble[TABLE_LOW_IDX]};
  assign busNib   = regAddr <= ADDR_NIB_LAST;
  assign romWrite = regWr && regAddr[ROM_SEL];

  always_comb begin
    unique case (opKind)
      OP_BRANCH: jumpTaken = 1'b1;
      OP_JC:     jumpTaken = carryBit;
      OP_JNC:    jumpTaken = !carryBit;
      OP_JF:     jumpTaken = statusFlag;
      OP_JNF:    jumpTaken = !statusFlag;
      default:   jumpTaken = 1'b0;
    endcase
  end

  always_comb begin
    if (opOperand[2:0] == COND_TIMER) begin
      checkTrue = timerZero;
    end else begin
      checkTrue = |keyReturnInputs;
    end
    if (opOperand[COND_SPECIAL]) begin
      checkTrue = checkTrue | specialInputZero | specialIoOne;
    end
  end

  // ----------------------------------------------------------------
  // instruction address counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      instructionAddressCounter <= PC_RESET;
    end else if (hang || fetchFault) begin
      instructionAddressCounter <= PC_RESET;
    end else if (doCall) begin
      instructionAddressCounter <= opOperand;
    end else if (doReturn) begin
      instructionAddressCounter <= returnStore;
    end else if (opValid && jumpTaken) begin
      instructionAddressCounter <= opOperand;
    end else if (opValid) begin
      instructionAddressCounter <= nextSeq;
    end
  end

  // only call, return and reset move the depth bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stackDepthBit <= 1'b0;
    end else if (hang) begin
      stackDepthBit <= 1'b0;
    end else if (doCall) begin
      stackDepthBit <= 1'b1;
    end else if (doReturn) begin
      stackDepthBit <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // return store upper bits, kept through reset
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (doCall) begin
      returnHigh <= nextSeq[9:8];
    end
  end

  // known flag survives reset along with the store itself
  always_ff @(posedge clk) begin
    if (doCall) begin
      returnHighKnown <= 1'b1;
    end else if ((regWr || regRd) && busNib &&
                 regAddr[3:0] == RET_LOW_IDX[3:0]) begin
      returnHighKnown <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // program memory
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (romWrite) begin
      programMemory[regAddr[8:0]] <= regWrData;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fetchWord <= 10'h000;
    end else if (fetchFault) begin
      fetchWord <= 10'h000;
    end else begin
      fetchWord <= programMemory[instructionAddressCounter[8:0]];
    end
  end

  // ----------------------------------------------------------------
  // data nibbles
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NIB_COUNT; i++) begin : g_nib
    localparam logic [4:0] IDX = 5'(i);
    localparam logic       CLR = (IDX == TABLE_LOW_IDX) ||
                                 (IDX == TABLE_HI_IDX);
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        if (CLR) begin
          dataNibble[i] <= 4'h0;
        end
      end else if (hang && CLR) begin
        dataNibble[i] <= 4'h0;
      end else if (doCall && IDX == RET_LOW_IDX) begin
        dataNibble[i] <= nextSeq[3:0];
      end else if (doCall && IDX == RET_HI_IDX) begin
        dataNibble[i] <= nextSeq[7:4];
      end else if (regWr && busNib && regAddr[4:0] == IDX) begin
        dataNibble[i] <= regWrData[3:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      controlRegZero <= CREG_RESET;
    end else if (hang) begin
      controlRegZero <= CREG_RESET;
    end else if (regWr && regAddr == ADDR_CREG) begin
      controlRegZero <= regWrData[7:0];
    end
  end

  // ----------------------------------------------------------------
  // accumulator and carry
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (opValid && !fetchFault) begin
      unique case (opKind)
        OP_AND:      accumulator <= accumulator & opOperand[3:0];
        OP_XOR:      accumulator <= accumulator ^ opOperand[3:0];
        OP_OR:       accumulator <= accumulator | opOperand[3:0];
        OP_RL:       accumulator <= {accumulator[2:0], accumulator[3]};
        OP_RLZ:      accumulator <= {accumulator[2:0], 1'b0};
        OP_INC,
        OP_STEP:     accumulator <= accumulator + 4'h1;
        OP_TRANSFER: accumulator <= opOperand[3:0];
        OP_PORT_IN:  accumulator <= portInData;
        default:     accumulator <= accumulator;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      carryBit <= 1'b0;
    end else if (opValid && !fetchFault) begin
      unique case (opKind)
        OP_AND,
        OP_XOR:      carryBit <= accumulator[3] & opOperand[3];
        OP_RL,
        OP_RLZ:      carryBit <= accumulator[3];
        OP_INC,
        OP_STEP:     carryBit <= accumulator == ACC_MAX;
        OP_OR,
        OP_TRANSFER,
        OP_PORT_IN:  carryBit <= 1'b0;
        default:     carryBit <= carryBit;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // status flag and standby request
  // ----------------------------------------------------------------
  logic isCheck;
  logic isPause;
  assign isCheck = opValid && !fetchFault && opKind == OP_CHECK;
  assign isPause = opValid && !fetchFault && opKind == OP_PAUSE;

  // a release arriving with a clearing instruction still sets
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      statusFlag <= 1'b0;
    end else if (standbyRelease) begin
      statusFlag <= 1'b1;
    end else if (isCheck) begin
      statusFlag <= checkTrue;
    end else if (isPause && pauseReleaseMet) begin
      statusFlag <= 1'b1;
    end else if (isPause && statusFlag) begin
      statusFlag <= 1'b0;
    end
  end

  assign standbyEnter = isPause && !pauseReleaseMet && !statusFlag;

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= 10'h000;
    end else if (regRd && regAddr[ROM_SEL]) begin
      regRdData <= programMemory[regAddr[8:0]];
    end else if (regRd && busNib) begin
      regRdData <= {6'h00, dataNibble[regAddr[4:0]]};
    end else if (regRd) begin
      unique case (regAddr)
        ADDR_CREG:  regRdData <= {2'h0, controlRegZero};
        ADDR_FLAGS: regRdData <= {6'h00, returnHighKnown, stackDepthBit,
                                  statusFlag, carryBit};
        ADDR_PC:    regRdData <= instructionAddressCounter;
        ADDR_RET:   regRdData <= returnHighKnown ? returnStore
                                 : {2'h0, returnStore[7:0]};
        ADDR_TABLE: regRdData <= tablePointer;
        ADDR_ACC:   regRdData <= {6'h00, accumulator};
        default:    regRdData <= 10'h000;
      endcase
    end else begin
      regRdData <= 10'h000;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence callOk;
    opValid && !fetchFault && opKind == OP_CALL && !stackDepthBit;
  endsequence
  sequence retOk;
    opValid && !fetchFault && opKind == OP_RET && stackDepthBit;
  endsequence

  stack_misuse_a: assert property (
    hang |=> instructionAddressCounter == PC_RESET && !stackDepthBit)
    else $error("misuse did not reset");
  call_save_a: assert property (
    callOk |=> stackDepthBit &&
    instructionAddressCounter == $past(opOperand) &&
    returnStore[7:0] == $past(nextSeq[7:0]))
    else $error("call failed");
  call_return_a: assert property (
    callOk ##2 retOk
    |=> instructionAddressCounter == $past(returnStore, 1))
    else $error("return address wrong");
  seq_advance_a: assert property (
    opValid && opKind == OP_NOP && !fetchFault
    |=> instructionAddressCounter == $past(nextSeq))
    else $error("counter did not advance");
  fetch_fault_a: assert property (
    instructionAddressCounter >= TEST_AREA_LO
    |=> instructionAddressCounter == PC_RESET)
    else $error("test area not redirected");
  carry_and_a: assert property (
    opValid && !fetchFault && opKind == OP_AND
    |=> carryBit == ($past(accumulator[3]) && $past(opOperand[3])))
    else $error("and carry wrong");
  carry_inc_a: assert property (
    opValid && !fetchFault && opKind == OP_INC
    |=> carryBit == ($past(accumulator) == ACC_MAX) &&
    accumulator == $past(accumulator) + 4'h1)
    else $error("increment carry wrong");
  check_status_a: assert property (
    isCheck && !standbyRelease
    |=> statusFlag == $past(checkTrue))
    else $error("check flag wrong");
  pause_clear_a: assert property (
    isPause && statusFlag && !pauseReleaseMet && !standbyRelease
    |-> !standbyEnter ##1 !statusFlag)
    else $error("pause did not clear");

endmodule

`default_nettype wire

/* File: testbench/testbench.sv */
// self-checking bench for the sequencer, return store and flag core
// assumes the core package and module are compiled ahead of this file
`timescale 1ns/1ns
`default_nettype none

module testbench
  import cpu_seq_pkg::*;
;
  logic              clk, rstN, opValid, specialInputZero, specialIoOne;
  logic              timerZero, standbyRelease, pauseReleaseMet;
  logic              regWr, regRd, fetchFault, systemResetPulse;
  logic              standbyEnter, carryBit, statusFlag, rstSeen, stbySeen;
  op_kind_t          opKind;
  logic [9:0]        opOperand, regWrData, regRdData, fetchWord, rdVal;
  logic [9:0]        instructionAddressCounter, tablePointer;
  logic [1:0]        opLength;
  logic [3:0]        keyReturnInputs, portInData, accumulator;
  logic [ADDR_W-1:0] regAddr;
  int                nFail, comparisons;
  op_kind_t          cyOp[13];
  logic [3:0]        cyAcc[13], cyOpd[13], stCode[4];
  logic              cyExp[13];
  logic [9:0]        badAddr[3];

  cpu_sequencer_and_flags dut (
    .clk, .rst_n(rstN), .opValid, .opKind, .opOperand, .opLength,
    .keyReturnInputs, .specialInputZero, .specialIoOne, .timerZero,
    .standbyRelease, .pauseReleaseMet, .portInData, .regAddr, .regWrData,
    .regWr, .regRd, .regRdData, .instructionAddressCounter, .fetchWord,
    .fetchFault, .systemResetPulse, .standbyEnter, .tablePointer,
    .accumulator, .carryBit, .statusFlag);

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic checkVal(input logic [9:0] got, input logic [9:0] exp);
    comparisons++;
    if (got !== exp) begin
      nFail++;
      $display("mismatch at %0t ns: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // pulse outputs are captured in the cycle the op is presented
  task automatic doOp(input op_kind_t k, input logic [9:0] opd,
                      input logic [1:0] len);
    @(posedge clk);
    opValid   <= 1'b1;
    opKind    <= k;
    opOperand <= opd;
    opLength  <= len;
    #1;
    rstSeen  = systemResetPulse;
    stbySeen = standbyEnter;
    @(posedge clk);
    opValid <= 1'b0;
    #1;
  endtask

  task automatic regWrite(input logic [ADDR_W-1:0] a, input logic [9:0] d);
    @(posedge clk);
    regWr     <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
    #1;
  endtask

  task automatic regRead(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    rdVal = regRdData;
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", comparisons, nFail);
    if (nFail == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    #2000000;
    nFail++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rstN = 1'b0;
    opValid = 1'b0;
    opKind = OP_NOP;
    opOperand = 10'h000;
    opLength = 2'h1;
    keyReturnInputs = 4'h0;
    specialInputZero = 1'b0;
    specialIoOne = 1'b0;
    timerZero = 1'b0;
    standbyRelease = 1'b0;
    pauseReleaseMet = 1'b0;
    portInData = 4'h0;
    regAddr = '0;
    regWrData = 10'h000;
    regWr = 1'b0;
    regRd = 1'b0;
    nFail = 0;
    comparisons = 0;
    cyOp = '{OP_AND, OP_AND, OP_AND, OP_XOR, OP_XOR, OP_RL, OP_RL, OP_RLZ,
             OP_RLZ, OP_INC, OP_INC, OP_STEP, OP_STEP};
    cyAcc = '{4'h8, 4'h8, 4'h7, 4'hC, 4'h4, 4'h9, 4'h6, 4'h8, 4'h7, 4'hF,
              4'hE, 4'hF, 4'h0};
    cyOpd = '{4'h8, 4'h7, 4'h8, 4'h9, 4'hF, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0,
              4'h0, 4'h0, 4'h0};
    cyExp = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1,
              1'b0, 1'b1, 1'b0};
    stCode = '{4'h0, 4'h3, 4'h6, 4'h5};
    badAddr = '{10'h200, 10'h3EA, 10'h3FF};
    repeat (5) @(posedge clk);
    rstN <= 1'b1;
    #1;
    checkVal(instructionAddressCounter, PC_RESET);
    checkVal(tablePointer, 10'h000);
    regRead(ADDR_FLAGS);
    checkVal(rdVal & 10'h007, 10'h000);
    regRead(ADDR_CREG);
    checkVal(rdVal, 10'(CREG_RESET));
    doOp(OP_NOP, 10'h000, 2'h2);
    checkVal(instructionAddressCounter, 10'h002);
    doOp(OP_NOP, 10'h000, 2'h1);
    checkVal(instructionAddressCounter, 10'h003);
    doOp(OP_BRANCH, 10'h155, 2'h1);
    checkVal(instructionAddressCounter, 10'h155);
    doOp(OP_CALL, 10'h0A0, 2'h2);
    checkVal(instructionAddressCounter, 10'h0A0);
    regRead(ADDR_FLAGS);
    checkVal(rdVal & 10'h004, 10'h004);
    regRead(ADDR_RET);
    checkVal(rdVal, 10'h157);
    doOp(OP_RET, 10'h000, 2'h1);
    checkVal(instructionAddressCounter, 10'h157);
    regRead(ADDR_FLAGS);
    checkVal(rdVal & 10'h004, 10'h000);
    regRead(ADDR_RET);
    checkVal(rdVal, 10'h157);
    $display("test flow_and_call done");

    regWrite(ADDR_CREG, 10'h030);
    regWrite(11'h000, 10'h005);
    regWrite(11'h010, 10'h00A);
    checkVal(tablePointer, 10'h3A5);
    doOp(OP_RET, 10'h000, 2'h1);
    checkVal(10'(rstSeen), 10'h001);
    checkVal(instructionAddressCounter, 10'h000);
    checkVal(tablePointer, 10'h000);
    doOp(OP_CALL, 10'h040, 2'h1);
    checkVal(10'(rstSeen), 10'h000);
    doOp(OP_CALL, 10'h080, 2'h1);
    checkVal(10'(rstSeen), 10'h001);
    checkVal(instructionAddressCounter, 10'h000);
    regWrite(ADDR_FLAGS, 10'h004);
    regRead(ADDR_FLAGS);
    checkVal(rdVal & 10'h004, 10'h000);
    $display("test stack_misuse done");

    doOp(OP_BRANCH, 10'h1F0, 2'h1);
    doOp(OP_CALL, 10'h010, 2'h2);
    doOp(OP_RET, 10'h000, 2'h1);
    checkVal(instructionAddressCounter, 10'h1F2);
    regWrite(11'h001, 10'h007);
    regWrite(11'h000, 10'h005);
    @(posedge clk);
    rstN <= 1'b0;
    repeat (2) @(posedge clk);
    rstN <= 1'b1;
    #1;
    checkVal(instructionAddressCounter, 10'h000);
    regRead(ADDR_RET);
    checkVal(rdVal, 10'h1F2);
    regRead(11'h001);
    checkVal(rdVal, 10'h007);
    regRead(11'h000);
    checkVal(rdVal, 10'h000);
    regRead(ADDR_NIB_LAST);
    regRead(ADDR_RET);
    checkVal(rdVal, 10'h0F2);
    $display("test reset_keep done");

    regWrite(11'h5FF, 10'h2A5);
    doOp(OP_BRANCH, 10'h1FF, 2'h1);
    checkVal(10'(fetchFault), 10'h000);
    @(posedge clk);
    #1;
    checkVal(fetchWord, 10'h2A5);
    regRead(11'h5FF);
    checkVal(rdVal, 10'h2A5);
    for (int i = 0; i < 3; i++) begin
      doOp(OP_BRANCH, badAddr[i], 2'h1);
      checkVal(10'(fetchFault), 10'h001);
      @(posedge clk);
      #1;
      checkVal(instructionAddressCounter, 10'h000);
    end
    $display("test fetch_map done");

    for (int i = 0; i < 13; i++) begin
      doOp(OP_TRANSFER, {6'h00, cyAcc[i]}, 2'h1);
      checkVal(10'(accumulator), 10'(cyAcc[i]));
      doOp(cyOp[i], {6'h00, cyOpd[i]}, 2'h1);
      checkVal(10'(carryBit), 10'(cyExp[i]));
    end
    doOp(OP_TRANSFER, 10'h008, 2'h1);
    doOp(OP_RL, 10'h000, 2'h1);
    doOp(OP_NOP, 10'h000, 2'h1);
    checkVal(10'(carryBit), 10'h001);
    doOp(OP_OR, 10'h000, 2'h1);
    checkVal(10'(carryBit), 10'h000);
    doOp(OP_TRANSFER, 10'h00F, 2'h1);
    doOp(OP_INC, 10'h000, 2'h1);
    doOp(OP_JNC, 10'h100, 2'h2);
    checkVal(instructionAddressCounter, 10'h022);
    doOp(OP_JC, 10'h120, 2'h1);
    checkVal(instructionAddressCounter, 10'h120);
    portInData <= 4'h6;
    doOp(OP_PORT_IN, 10'h000, 2'h1);
    checkVal(10'(accumulator), 10'h006);
    checkVal(10'(carryBit), 10'h000);
    doOp(OP_JNC, 10'h130, 2'h1);
    checkVal(instructionAddressCounter, 10'h130);
    $display("test carry_rules done");

    for (int i = 0; i < 4; i++) begin
      keyReturnInputs <= (stCode[i] == 4'h5) ? 4'h0 : 4'h4;
      timerZero       <= (stCode[i] == 4'h5);
      doOp(OP_CHECK, {6'h00, stCode[i]}, 2'h1);
      checkVal(10'(statusFlag), 10'h001);
      keyReturnInputs <= (stCode[i] == 4'h5) ? 4'hF : 4'h0;
      timerZero       <= (stCode[i] != 4'h5);
      doOp(OP_CHECK, {6'h00, stCode[i]}, 2'h1);
      checkVal(10'(statusFlag), 10'h000);
    end
    keyReturnInputs <= 4'h0;
    timerZero       <= 1'b0;
    specialIoOne    <= 1'b1;
    doOp(OP_CHECK, 10'h008, 2'h1);
    checkVal(10'(statusFlag), 10'h001);
    doOp(OP_CHECK, 10'h000, 2'h1);
    checkVal(10'(statusFlag), 10'h000);
    specialIoOne     <= 1'b0;
    specialInputZero <= 1'b1;
    doOp(OP_CHECK, 10'h00D, 2'h1);
    checkVal(10'(statusFlag), 10'h001);
    specialInputZero <= 1'b0;
    doOp(OP_JF, 10'h050, 2'h1);
    checkVal(instructionAddressCounter, 10'h050);
    doOp(OP_PAUSE, 10'h000, 2'h1);
    checkVal(10'(statusFlag), 10'h000);
    checkVal(10'(stbySeen), 10'h000);
    doOp(OP_PAUSE, 10'h000, 2'h1);
    checkVal(10'(stbySeen), 10'h001);
    pauseReleaseMet <= 1'b1;
    doOp(OP_PAUSE, 10'h000, 2'h1);
    checkVal(10'(statusFlag), 10'h001);
    checkVal(10'(stbySeen), 10'h000);
    pauseReleaseMet <= 1'b0;
    doOp(OP_CHECK, 10'h000, 2'h1);
    @(posedge clk);
    standbyRelease <= 1'b1;
    @(posedge clk);
    standbyRelease <= 1'b0;
    #1;
    checkVal(10'(statusFlag), 10'h001);
    doOp(OP_JNF, 10'h060, 2'h1);
    checkVal(instructionAddressCounter, 10'h055);
    $display("test status_rules done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
